// ===== logic/bcd_shift_bit_alu_cfg.svh
// offsets, field positions, reset values and constants of the datapath
`ifndef BCD_SHIFT_BIT_ALU_CFG_SVH
`define BCD_SHIFT_BIT_ALU_CFG_SVH

// register byte addresses
`define ADDR_OPND_A     8'h00
`define ADDR_OPND_B     8'h04
`define ADDR_SHIFT_CTRL 8'h08
`define ADDR_FLAGS      8'h0c
`define ADDR_COMMAND    8'h10

// status word bit positions
`define FLAG_CF 0
`define FLAG_PF 2
`define FLAG_AF 4
`define FLAG_ZF 6
`define FLAG_SF 7
`define FLAG_OF 11

// shift control field positions
`define COUNT_LSB 0
`define COUNT_MSB 4
`define COND_LSB  8
`define COND_MSB  11
`define OPCODE_MSB 4

// reset values
`define WORD_RESET  32'h0000_0000
`define COUNT_RESET 5'h00
`define COND_RESET  4'h0

// decimal adjust constants
`define NIBBLE_LIMIT 4'h9
`define LOW_FIX      8'h06
`define HIGH_FIX     8'h60
`define BYTE_LIMIT   8'h99
`define DECIMAL_BASE 8'h0a
`define DIGIT_MASK   8'h0f
`define BYTE_ONE     8'h01

// rotate widths
`define ROT_WIDTH   6'h20
`define CHAIN_WIDTH 6'h21

`endif

// ===== logic/bcd_shift_bit_alu_pkg.sv
// types shared by the datapath slice
package bcd_shift_bit_alu_pkg;

	// operation codes written to the command register
	typedef enum logic [4:0] {
		op_and                  = 5'h00,
		op_or                   = 5'h01,
		op_xor                  = 5'h02,
		op_not                  = 5'h03,
		op_arith_left_shift     = 5'h04,
		op_logic_left_shift     = 5'h05,
		op_logic_right_shift    = 5'h06,
		op_arith_right_shift    = 5'h07,
		op_double_left_shift    = 5'h08,
		op_double_right_shift   = 5'h09,
		op_circular_left        = 5'h0a,
		op_circular_right       = 5'h0b,
		op_carry_circular_left  = 5'h0c,
		op_carry_circular_right = 5'h0d,
		op_bit_probe            = 5'h0e,
		op_bit_probe_set        = 5'h0f,
		op_bit_probe_clear      = 5'h10,
		op_bit_probe_invert     = 5'h11,
		op_scan_up_first_one    = 5'h12,
		op_scan_down_first_one  = 5'h13,
		op_conditional_byte_set = 5'h14,
		op_overflow_byte_set    = 5'h15,
		op_packed_add_adjust    = 5'h16,
		op_packed_sub_adjust    = 5'h17,
		op_unpacked_add_adjust  = 5'h18,
		op_unpacked_sub_adjust  = 5'h19,
		op_unpacked_mul_adjust  = 5'h1a,
		op_unpacked_div_prepare = 5'h1b,
		op_compare              = 5'h1c
	} op_type;

	// arithmetic status flags
	typedef struct packed {
		logic overflow_flag;
		logic sign_flag;
		logic zero_flag;
		logic aux_flag;
		logic parity_flag;
		logic carry_flag;
	} flags_type;

endpackage

// ===== logic/bcd_shift_bit_alu.sv
// bcd adjust, logic, shift, rotate, bit and byte-set datapath with apb
//
// Summary of operation
// - packed add adjust fixes byte, sets carry
// - packed sub adjust fixes byte, sets borrow
// - unpacked add adjust leaves one digit, upper zero
// - unpacked add carry sets carry, bumps high byte
// - unpacked sub adjust borrows from high byte
// - unpacked mul adjust splits product into digits
// - unpacked div prepare merges two digits binary
// - and, or, xor, not are provided
// - left shifts zero fill, carry last out
// - logical right shift zero fills, carry last
// - arithmetic right shift fills with sign
// - double left shift fills from source
// - rotates lose no bits, count 0..31
// - carry left rotate chains carry above operand
// - carry right rotate chains carry too
// - every rotate leaves last bit in carry
// - bit probes copy bit to carry; set, clear and invert also modify
// - upward scan reports first set index
// - downward scan reports first set index
// - conditional byte set writes one or zero
// - overflow byte set follows overflow flag
// - compare updates flags, writes no result
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`include "bcd_shift_bit_alu_cfg.svh"

module bcd_shift_bit_alu (
	input  wire logic        pclk,    // core clock
	input  wire logic        presetn, // asynchronous reset, active low
	input  wire logic        psel,    // apb select
	input  wire logic        penable, // apb access phase
	input  wire logic        pwrite,  // apb direction
	input  wire logic [7:0]  paddr,   // apb byte address
	input  wire logic [31:0] pwdata,  // apb write data
	output logic      [31:0] prdata,  // apb read data
	output logic             pready,  // apb ready
	output logic             pslverr  // apb error on unmapped address
);

	// ****************************************************************
	// helper functions
	// ****************************************************************

	// even parity of the low byte
	function automatic logic parity_of(input logic [7:0] v);
		parity_of = ~(^v);
	endfunction

	// sign, zero and parity from a result word
	function automatic bcd_shift_bit_alu_pkg::flags_type result_flags(
		input bcd_shift_bit_alu_pkg::flags_type f,
		input logic [31:0]                      r
	);
		result_flags             = f;
		result_flags.sign_flag   = r[31];
		result_flags.zero_flag   = (r == `WORD_RESET);
		result_flags.parity_flag = parity_of(r[7:0]);
	endfunction

	// index of the first set bit, upward or downward
	function automatic logic [4:0] scan_index(
		input logic [31:0] v,
		input logic        downward
	);
		scan_index = 5'h00;
		for (int i = 0; i < 32; i++) begin
			if (downward && v[i]) begin
				scan_index = 5'(i);
			end
		end
		for (int i = 31; i >= 0; i--) begin
			if (!downward && v[i]) begin
				scan_index = 5'(i);
			end
		end
	endfunction

	// condition test over the status flags
	function automatic logic cond_met(
		input bcd_shift_bit_alu_pkg::flags_type f,
		input logic [3:0]                       code
	);
		logic base;
		base = 1'b0;
		case (code[3:1])
			3'h0: base = f.overflow_flag;
			3'h1: base = f.carry_flag;
			3'h2: base = f.zero_flag;
			3'h3: base = f.carry_flag | f.zero_flag;
			3'h4: base = f.sign_flag;
			3'h5: base = f.parity_flag;
			3'h6: base = f.sign_flag ^ f.overflow_flag;
			3'h7: base = (f.sign_flag ^ f.overflow_flag) | f.zero_flag;
			default: base = 1'b0;
		endcase
		cond_met = base ^ code[0];
	endfunction

	// ****************************************************************
	// state
	// ****************************************************************

	logic [31:0]                      opnd_a;     // destination, accumulator
	logic [31:0]                      opnd_b;     // source, bit offset
	logic [4:0]                       count;      // shift and rotate count
	logic [3:0]                       cond_code;  // byte-set condition
	bcd_shift_bit_alu_pkg::flags_type flags;      // status word flags
	bcd_shift_bit_alu_pkg::op_type    last_op;    // last command issued

	logic                             access;     // apb transfer completes
	logic                             wr_access;  // completing write
	logic                             mapped;     // address decodes
	logic                             exec;       // command write strobe
	bcd_shift_bit_alu_pkg::op_type    cmd_op;     // opcode being written

	logic [31:0]                      next_a;     // computed destination
	bcd_shift_bit_alu_pkg::flags_type next_f;     // computed flags
	logic [31:0]                      next_rdata; // read mux
	logic [31:0]                      flag_word;  // flags as a word

	logic [8:0]                       t9;         // decimal adjust sum
	logic [7:0]                       al;         // low accumulator byte
	logic [7:0]                       ah;         // high accumulator byte
	logic [32:0]                      chain;      // shift with carry
	logic [64:0]                      wide;       // double shift chain
	logic [4:0]                       idx;        // bit probe index

	// ****************************************************************
	// bus decode
	// ****************************************************************

	// a transfer takes effect at the edge that samples pready high
	assign access    = psel & penable & pready;
	assign wr_access = access & pwrite;
	assign exec      = wr_access && (paddr == `ADDR_COMMAND);
	assign cmd_op    = bcd_shift_bit_alu_pkg::op_type'(
		pwdata[`OPCODE_MSB:0]);
	assign al        = opnd_a[7:0];
	assign ah        = opnd_a[15:8];
	assign idx       = opnd_b[4:0];

	// address decode
	always_comb begin
		case (paddr)
			`ADDR_OPND_A, `ADDR_OPND_B, `ADDR_SHIFT_CTRL,
			`ADDR_FLAGS, `ADDR_COMMAND: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// flags packed into the status word layout
	always_comb begin
		flag_word              = `WORD_RESET;
		flag_word[`FLAG_CF]    = flags.carry_flag;
		flag_word[`FLAG_PF]    = flags.parity_flag;
		flag_word[`FLAG_AF]    = flags.aux_flag;
		flag_word[`FLAG_ZF]    = flags.zero_flag;
		flag_word[`FLAG_SF]    = flags.sign_flag;
		flag_word[`FLAG_OF]    = flags.overflow_flag;
	end

	// read data mux, unmapped reads as zero
	always_comb begin
		next_rdata = `WORD_RESET;
		case (paddr)
			`ADDR_OPND_A: next_rdata = opnd_a;
			`ADDR_OPND_B: next_rdata = opnd_b;
			`ADDR_SHIFT_CTRL: begin
				next_rdata[`COUNT_MSB:`COUNT_LSB] = count;
				next_rdata[`COND_MSB:`COND_LSB]   = cond_code;
			end
			`ADDR_FLAGS: next_rdata = flag_word;
			`ADDR_COMMAND: next_rdata = 32'(last_op);
			default: next_rdata = `WORD_RESET;
		endcase
	end

	// ****************************************************************
	// execution datapath
	// ****************************************************************

	// result and flags of the operation in cmd_op
	always_comb begin
		next_a = opnd_a;
		next_f = flags;
		t9     = {1'b0, al};
		chain  = {flags.carry_flag, opnd_a};
		wide   = {1'b0, opnd_a, opnd_b};
		case (cmd_op)
			bcd_shift_bit_alu_pkg::op_and: begin
				next_a = opnd_a & opnd_b;
				next_f = result_flags(flags, next_a);
				next_f.carry_flag    = 1'b0;
				next_f.overflow_flag = 1'b0;
			end
			bcd_shift_bit_alu_pkg::op_or: begin
				next_a = opnd_a | opnd_b;
				next_f = result_flags(flags, next_a);
				next_f.carry_flag    = 1'b0;
				next_f.overflow_flag = 1'b0;
			end
			bcd_shift_bit_alu_pkg::op_xor: begin
				next_a = opnd_a ^ opnd_b;
				next_f = result_flags(flags, next_a);
				next_f.carry_flag    = 1'b0;
				next_f.overflow_flag = 1'b0;
			end
			bcd_shift_bit_alu_pkg::op_not: begin
				next_a = ~opnd_a;
			end
			// both left shift codes share one path
			bcd_shift_bit_alu_pkg::op_arith_left_shift,
			bcd_shift_bit_alu_pkg::op_logic_left_shift: begin
				chain = {1'b0, opnd_a} << count;
				if (count != `COUNT_RESET) begin
					next_a = chain[31:0];
					next_f = result_flags(flags, next_a);
					next_f.carry_flag = chain[32];
				end
			end
			bcd_shift_bit_alu_pkg::op_logic_right_shift: begin
				chain = {opnd_a, 1'b0} >> count;
				if (count != `COUNT_RESET) begin
					next_a = chain[32:1];
					next_f = result_flags(flags, next_a);
					next_f.carry_flag = chain[0];
				end
			end
			bcd_shift_bit_alu_pkg::op_arith_right_shift: begin
				// signed shift copies the original sign bit
				chain = 33'($signed({opnd_a, 1'b0}) >>> count);
				if (count != `COUNT_RESET) begin
					next_a = chain[32:1];
					next_f = result_flags(flags, next_a);
					next_f.carry_flag = chain[0];
				end
			end
			bcd_shift_bit_alu_pkg::op_double_left_shift: begin
				// source bits enter from below, source unchanged
				wide = {1'b0, opnd_a, opnd_b} << count;
				if (count != `COUNT_RESET) begin
					next_a = wide[63:32];
					next_f = result_flags(flags, next_a);
					next_f.carry_flag = wide[64];
				end
			end
			bcd_shift_bit_alu_pkg::op_double_right_shift: begin
				// source low bits enter from above
				wide = {opnd_b, opnd_a, 1'b0} >> count;
				if (count != `COUNT_RESET) begin
					next_a = wide[32:1];
					next_f = result_flags(flags, next_a);
					next_f.carry_flag = wide[0];
				end
			end
			bcd_shift_bit_alu_pkg::op_circular_left: begin
				next_a = (opnd_a << count) |
					(opnd_a >> (`ROT_WIDTH - {1'b0, count}));
				if (count != `COUNT_RESET) begin
					next_f.carry_flag = next_a[0];
				end
			end
			bcd_shift_bit_alu_pkg::op_circular_right: begin
				next_a = (opnd_a >> count) |
					(opnd_a << (`ROT_WIDTH - {1'b0, count}));
				if (count != `COUNT_RESET) begin
					next_f.carry_flag = next_a[31];
				end
			end
			bcd_shift_bit_alu_pkg::op_carry_circular_left: begin
				// 33-bit chain with the carry on top
				chain = ({flags.carry_flag, opnd_a} << count) |
					({flags.carry_flag, opnd_a} >>
					(`CHAIN_WIDTH - {1'b0, count}));
				next_a = chain[31:0];
				next_f.carry_flag = chain[32];
			end
			bcd_shift_bit_alu_pkg::op_carry_circular_right: begin
				chain = ({flags.carry_flag, opnd_a} >> count) |
					({flags.carry_flag, opnd_a} <<
					(`CHAIN_WIDTH - {1'b0, count}));
				next_a = chain[31:0];
				next_f.carry_flag = chain[32];
			end
			bcd_shift_bit_alu_pkg::op_bit_probe: begin
				next_f.carry_flag = opnd_a[idx];
			end
			bcd_shift_bit_alu_pkg::op_bit_probe_set: begin
				next_f.carry_flag = opnd_a[idx];
				next_a[idx] = 1'b1;
			end
			bcd_shift_bit_alu_pkg::op_bit_probe_clear: begin
				next_f.carry_flag = opnd_a[idx];
				next_a[idx] = 1'b0;
			end
			bcd_shift_bit_alu_pkg::op_bit_probe_invert: begin
				next_f.carry_flag = opnd_a[idx];
				next_a[idx] = ~opnd_a[idx];
			end
			// empty source: zero flag set, destination kept
			bcd_shift_bit_alu_pkg::op_scan_up_first_one: begin
				next_f.zero_flag = (opnd_b == `WORD_RESET);
				if (opnd_b != `WORD_RESET) begin
					next_a = 32'(scan_index(opnd_b, 1'b0));
				end
			end
			bcd_shift_bit_alu_pkg::op_scan_down_first_one: begin
				next_f.zero_flag = (opnd_b == `WORD_RESET);
				if (opnd_b != `WORD_RESET) begin
					next_a = 32'(scan_index(opnd_b, 1'b1));
				end
			end
			bcd_shift_bit_alu_pkg::op_conditional_byte_set: begin
				next_a[7:0] = 8'(cond_met(flags, cond_code));
			end
			bcd_shift_bit_alu_pkg::op_overflow_byte_set: begin
				next_a[7:0] = 8'(flags.overflow_flag);
			end
			bcd_shift_bit_alu_pkg::op_packed_add_adjust: begin
				next_f.aux_flag   = 1'b0;
				next_f.carry_flag = 1'b0;
				if (al[3:0] > `NIBBLE_LIMIT || flags.aux_flag) begin
					t9 = t9 + {1'b0, `LOW_FIX};
					next_f.aux_flag = 1'b1;
				end
				if (al > `BYTE_LIMIT || flags.carry_flag) begin
					t9 = t9 + {1'b0, `HIGH_FIX};
					next_f.carry_flag = 1'b1;
				end
				next_a[7:0] = t9[7:0];
				next_f = result_flags(next_f, {24'(0), t9[7:0]});
				next_f.sign_flag  = t9[7];
				next_f.carry_flag = next_f.carry_flag | t9[8];
			end
			bcd_shift_bit_alu_pkg::op_packed_sub_adjust: begin
				next_f.aux_flag   = 1'b0;
				next_f.carry_flag = 1'b0;
				if (al[3:0] > `NIBBLE_LIMIT || flags.aux_flag) begin
					t9 = t9 - {1'b0, `LOW_FIX};
					next_f.aux_flag   = 1'b1;
					next_f.carry_flag = t9[8];
				end
				if (al > `BYTE_LIMIT || flags.carry_flag) begin
					t9 = {1'b0, t9[7:0] - `HIGH_FIX};
					next_f.carry_flag = 1'b1;
				end
				next_a[7:0] = t9[7:0];
				next_f = result_flags(next_f, {24'(0), t9[7:0]});
				next_f.sign_flag = t9[7];
			end
			bcd_shift_bit_alu_pkg::op_unpacked_add_adjust: begin
				next_f.aux_flag   = 1'b0;
				next_f.carry_flag = 1'b0;
				next_a[7:0] = al & `DIGIT_MASK;
				if (al[3:0] > `NIBBLE_LIMIT || flags.aux_flag) begin
					next_a[7:0]  = (al + `LOW_FIX) & `DIGIT_MASK;
					next_a[15:8] = ah + `BYTE_ONE;
					next_f.aux_flag   = 1'b1;
					next_f.carry_flag = 1'b1;
				end
			end
			bcd_shift_bit_alu_pkg::op_unpacked_sub_adjust: begin
				next_f.aux_flag   = 1'b0;
				next_f.carry_flag = 1'b0;
				next_a[7:0] = al & `DIGIT_MASK;
				if (al[3:0] > `NIBBLE_LIMIT || flags.aux_flag) begin
					next_a[7:0]  = (al - `LOW_FIX) & `DIGIT_MASK;
					next_a[15:8] = ah - `BYTE_ONE;
					next_f.aux_flag   = 1'b1;
					next_f.carry_flag = 1'b1;
				end
			end
			bcd_shift_bit_alu_pkg::op_unpacked_mul_adjust: begin
				next_a[15:8] = al / `DECIMAL_BASE;
				next_a[7:0]  = al % `DECIMAL_BASE;
				next_f = result_flags(flags, {24'(0), next_a[7:0]});
				next_f.sign_flag = next_a[7];
			end
			bcd_shift_bit_alu_pkg::op_unpacked_div_prepare: begin
				next_a[7:0]  = al + ah * `DECIMAL_BASE;
				next_a[15:8] = 8'h00;
				next_f = result_flags(flags, {24'(0), next_a[7:0]});
				next_f.sign_flag = next_a[7];
			end
			bcd_shift_bit_alu_pkg::op_compare: begin
				// difference sets flags only, nothing written back
				chain = {1'b0, opnd_a} - {1'b0, opnd_b};
				next_f = result_flags(flags, chain[31:0]);
				next_f.carry_flag    = chain[32];
				next_f.aux_flag      = opnd_a[4] ^ opnd_b[4] ^ chain[4];
				next_f.overflow_flag = (opnd_a[31] ^ opnd_b[31]) &
					(chain[31] ^ opnd_a[31]);
			end
			default: begin
				next_a = opnd_a;
				next_f = flags;
			end
		endcase
	end

	// ****************************************************************
	// registers
	// ****************************************************************

	// apb ready: one wait state in every access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= psel & penable & ~pready;
		end
	end

	// read data and error captured as ready rises
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= `WORD_RESET;
			pslverr <= 1'b0;
		end else if (psel && penable && !pready) begin
			prdata  <= pwrite ? `WORD_RESET : next_rdata;
			pslverr <= ~mapped;
		end else begin
			prdata  <= `WORD_RESET;
			pslverr <= 1'b0;
		end
	end

	// destination operand: bus write or command result
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			opnd_a <= `WORD_RESET;
		end else if (exec) begin
			opnd_a <= next_a;
		end else if (wr_access && paddr == `ADDR_OPND_A) begin
			opnd_a <= pwdata;
		end
	end

	// source operand, never modified by a command
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			opnd_b <= `WORD_RESET;
		end else if (wr_access && paddr == `ADDR_OPND_B) begin
			opnd_b <= pwdata;
		end
	end

	// shift count and condition selection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count     <= `COUNT_RESET;
			cond_code <= `COND_RESET;
		end else if (wr_access && paddr == `ADDR_SHIFT_CTRL) begin
			count     <= pwdata[`COUNT_MSB:`COUNT_LSB];
			cond_code <= pwdata[`COND_MSB:`COND_LSB];
		end
	end

	// status flags: command result or bus write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags <= '0;
		end else if (exec) begin
			flags <= next_f;
		end else if (wr_access && paddr == `ADDR_FLAGS) begin
			flags.carry_flag    <= pwdata[`FLAG_CF];
			flags.parity_flag   <= pwdata[`FLAG_PF];
			flags.aux_flag      <= pwdata[`FLAG_AF];
			flags.zero_flag     <= pwdata[`FLAG_ZF];
			flags.sign_flag     <= pwdata[`FLAG_SF];
			flags.overflow_flag <= pwdata[`FLAG_OF];
		end
	end

	// last issued opcode for read back
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_op <= bcd_shift_bit_alu_pkg::op_and;
		end else if (exec) begin
			last_op <= cmd_op;
		end
	end

endmodule

// ===== testbench/bcd_shift_bit_alu_assertions.sv
// apb answer checks for the bcd shift bit datapath
`timescale 1ns/100ps
module bcd_shift_bit_alu_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr
);
	// ****
	// handshake and read-back relations
	// ****
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// the answer follows exactly one wait state
	property p_one_wait;
		psel && penable && !pready |=> pready;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("late ready");
	// ready only inside an access, one cycle long
	property p_ready_pulse;
		pready |-> psel && penable ##1 !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("bad ready");
	// no answer in a setup cycle
	property p_setup_quiet;
		psel && !penable |-> !pready;
	endproperty
	a_setup_quiet: assert property (p_setup_quiet) else $error("early ready");
	// error exactly for unaligned or unmapped addresses
	property p_err_map;
		pready |-> pslverr == (paddr[1:0] != 2'h0 || paddr > 8'h10);
	endproperty
	a_err_map: assert property (p_err_map) else $error("wrong error");
	// an error comes with ready and empty data
	property p_err_ready;
		pslverr |-> pready && prdata == 32'h0;
	endproperty
	a_err_ready: assert property (p_err_ready) else $error("stray error");
	// read data is zero outside a read answer
	property p_rdata_idle;
		!(pready && !pwrite) |-> prdata == 32'h0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("stray data");
	// unused flag bits read zero
	property p_flag_bits;
		pready && !pwrite && paddr == 8'h0c |-> (prdata & 32'hfffff72a) == 0;
	endproperty
	a_flag_bits: assert property (p_flag_bits) else $error("flag bits");
	// unused control bits read zero
	property p_ctrl_bits;
		pready && !pwrite && paddr == 8'h08 |-> (prdata & 32'hfffff0e0) == 0;
	endproperty
	a_ctrl_bits: assert property (p_ctrl_bits) else $error("ctrl bits");
	// the command register holds five bits
	property p_cmd_bits;
		pready && !pwrite && paddr == 8'h10 |-> prdata[31:5] == 27'h0;
	endproperty
	a_cmd_bits: assert property (p_cmd_bits) else $error("cmd bits");
endmodule

// ===== testbench/decoder_model.sv
// register-file side model: issues apb requests for the bench
`timescale 1ns/100ps
module decoder_model (
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	// idle bus from time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	// setup, access until ready, then release with scrambled lines
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule

// ===== testbench/bcd_shift_bit_alu_bench.sv
// self-checking bench for the bcd shift bit datapath
`timescale 1ns/100ps
module bcd_shift_bit_alu_bench;
	localparam logic [31:0] ones = 32'hffffffff; // full mask
	localparam logic [31:0] nil  = 32'h00000000; // zero word
	localparam logic [31:0] cy   = 32'h00000001; // carry bit
	logic        pclk;        // core clock
	logic        presetn;     // reset, active low
	logic        psel;        // apb request, from the model
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;      // apb answer
	logic        pready;
	logic        pslverr;
	logic [31:0] rv;          // last read word
	logic        st;          // last error answer
	int          n_errors;    // mismatches
	int          checks_done; // comparisons
	bcd_shift_bit_alu bcd_shift_bit_alu_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	decoder_model decoder_model_inst (
		.pclk(pclk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	// ****
	// clock and helpers
	// ****
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// masked compare, counted
	task automatic cmp(input logic [31:0] got, exp, m);
		checks_done++;
		if ((got & m) !== (exp & m)) begin
			n_errors++;
			$display("unexpected at %0t: %h vs %h", $time, got & m, exp & m);
		end
	endtask
	task automatic chk(input logic [7:0] a, input logic [31:0] exp, m);
		decoder_model_inst.xfer(1'b0, a, nil, rv, st);
		cmp(rv, exp, m);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		decoder_model_inst.xfer(1'b1, a, d, rv, st);
	endtask
	// load operands, control and flags, run an opcode, check a and flags
	task automatic t(input logic [4:0] c, input logic [31:0] a, ea, mf, ef,
		b = 32'h0, ctl = 32'h0, fl = 32'h0);
		wr(8'h00, a);
		wr(8'h04, b);
		wr(8'h08, ctl);
		wr(8'h0c, fl);
		wr(8'h10, {27'h0, c});
		chk(8'h00, ea, ones);
		chk(8'h0c, ef, mf);
	endtask
	// ****
	// scenarios
	// ****
	task automatic test_regs;
		for (int i = 0; i < 5; i++)
			chk(8'(4 * i), nil, ones);
		wr(8'h14, ones);
		cmp({31'h0, st}, cy, ones);
		chk(8'h02, nil, ones);
		cmp({31'h0, st}, cy, ones);
		t(5'h1d, nil, nil, ones, 32'h8d5, nil, ones, ones);
		chk(8'h08, 32'hf1f, ones);
		chk(8'h10, 32'h1d, ones);
		$display("registers done");
	endtask
	task automatic test_alu;
		t(5'h00, 32'hff00, 32'h0f00, cy, nil, 32'h0ff0, nil, cy);
		t(5'h01, 32'hff00, 32'hfff0, cy, nil, 32'h0ff0, nil, cy);
		t(5'h02, 32'hff00, 32'hf0f0, cy, nil, 32'h0ff0, nil, cy);
		t(5'h03, 32'hff00, 32'hffff00ff, ones, nil);
		t(5'h04, 32'h80000001, 32'h2, cy, cy, nil, 32'h1);
		t(5'h05, 32'h3, 32'h80000000, cy, cy, nil, 32'h1f);
		t(5'h06, 32'hc0000001, 32'h1, cy, cy, nil, 32'h1f);
		t(5'h07, 32'h80000000, 32'hf8000000, cy, nil, nil, 32'h4, cy);
		t(5'h08, 32'h12345678, 32'h23456789, cy, cy, 32'h9abcdef5, 32'h4);
		chk(8'h04, 32'h9abcdef5, ones);
		t(5'h09, 32'h12345678, 32'h51234567, cy, cy, 32'h9abcdef5, 32'h4);
		$display("logic and shifts done");
	endtask
	task automatic test_rotate_bits;
		t(5'h0a, 32'h80000001, 32'h3, cy, cy, nil, 32'h1);
		t(5'h0a, 32'h80000001, 32'hc0000000, cy, nil, nil, 32'h1f, cy);
		t(5'h0b, 32'h80000001, 32'hc0000000, cy, cy, nil, 32'h1);
		t(5'h0c, 32'h80000001, 32'h2, cy, cy, nil, 32'h1);
		t(5'h0c, nil, cy, cy, nil, nil, 32'h1, cy);
		t(5'h0d, 32'h80000000, 32'hc0000000, cy, nil, nil, 32'h1, cy);
		t(5'h0e, 32'h10, 32'h10, cy, cy, 32'h4);
		t(5'h0f, 32'h10, 32'h11, cy, nil, nil, nil, cy);
		t(5'h10, 32'h30, 32'h20, cy, cy, 32'h4);
		t(5'h11, 32'h10, 32'h80000010, cy, nil, 32'h1f);
		t(5'h12, 32'h5, 32'h8, 32'h40, nil, 32'h100100);
		t(5'h12, 32'h5, 32'h5, 32'h40, 32'h40);
		t(5'h13, 32'h5, 32'h14, 32'h40, nil, 32'h100100);
		$display("rotates, bits and scans done");
	endtask
	task automatic test_set;
		for (int f = 0; f < 2; f++)
			for (int c = 0; c < 16; c++)
				t(5'h14, 32'hffffff55, {24'hffffff, 7'h0,
					c[0] ^ (f == 1 && c[3:1] != 3'h6)}, nil, nil, nil,
					{20'h0, 4'(c), 8'h0}, (f == 1) ? 32'h8d5 : nil);
		t(5'h15, 32'hffffff00, 32'hffffff01, nil, nil, nil, nil, 32'h800);
		t(5'h15, 32'hffffff01, 32'hffffff00, nil, nil);
		$display("byte sets done");
	endtask
	task automatic test_bcd;
		t(5'h16, 32'h9a, 32'h00, cy, cy);
		t(5'h16, 32'h45, 32'h45, cy, nil);
		t(5'h17, 32'hff, 32'h99, cy, cy, nil, nil, 32'h11);
		t(5'h18, 32'h10b, 32'h201, cy, cy);
		t(5'h19, 32'h3ff, 32'h209, cy, cy, nil, nil, 32'h10);
		t(5'h1a, 32'h51, 32'h801, ones, nil);
		t(5'h1b, 32'h807, 32'h57, ones, nil);
		t(5'h1c, 32'h5, 32'h5, 32'h8c1, 32'h81, 32'h7);
		chk(8'h04, 32'h7, ones);
		$display("decimal and compare done");
	endtask
	initial begin
		n_errors = 0;
		checks_done = 0;
		presetn = 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		test_regs;
		test_alu;
		test_rotate_bits;
		test_set;
		test_bcd;
		test_done;
	end
	// watchdog: the tests need some 1900 cycles
	initial begin
		#100000;
		n_errors++;
		test_done;
	end
endmodule
bind bcd_shift_bit_alu bcd_shift_bit_alu_checker bcd_shift_bit_alu_checker_inst (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr));
